// ===== core/cbt_defines.svh
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define CBT_ADDR_DAC_BASE     8'h5A
`define CBT_ADDR_RATIO        8'h5E
`define CBT_ADDR_RANGE        8'h61
`define CBT_ADDR_STATUS       8'h62

// ************************************************************
// Reset values
// ************************************************************
`define CBT_RATIO_RST         8'hFF
`define CBT_DAC_RST           8'hBF
`define CBT_RANGE_RST         8'h00

// ************************************************************
// Field layout and limits
// ************************************************************
`define CBT_FIELD_W           2
`define CBT_RANGE_RESERVED    2'h3
`define CBT_DAC_ACCURATE_MIN  8'h66
`define CBT_STAT_FAULT_LSB    0
`define CBT_STAT_LOWDAC_LSB   4

// ************************************************************
// Ratio percentages
// ************************************************************
`define CBT_PCT_BASE          7'h64
`define CBT_PCT_125           8'h7D
`define CBT_PCT_150           8'h96
`define CBT_PCT_175           8'hAF
`define CBT_PCT_200           8'hC8

// ************************************************************
// Slow-trip timing
// ************************************************************
`define CBT_SLOW_LIMIT        16'h0400
`define CBT_SLOW_LEAK         16'h0004

`endif

// ===== core/cbt_pkg.sv
`default_nettype none

package cbt_pkg;

    // Full-scale range codes
    typedef enum logic [1:0] {
        CBT_FS_100MV = 2'h0,
        CBT_FS_50MV  = 2'h1,
        CBT_FS_25MV  = 2'h2,
        CBT_FS_NONE  = 2'h3
    } cbt_range_t;

    // Fast-to-slow ratio codes
    typedef enum logic [1:0] {
        CBT_RT_125 = 2'h0,
        CBT_RT_150 = 2'h1,
        CBT_RT_175 = 2'h2,
        CBT_RT_200 = 2'h3
    } cbt_ratio_t;

    // Per-channel breaker state
    typedef enum logic {
        CBT_ST_ARMED,
        CBT_ST_TRIPPED
    } cbt_trip_state_t;

endpackage

`default_nettype wire

// ===== core/cbt_thresh_calc.sv
`include "cbt_defines.svh"
`default_nettype none

module cbt_thresh_calc #(
    parameter int LVL_W = 10
) (
    // Settings
    input  wire logic [7:0]       i_dac,
    input  wire logic [1:0]       i_ratio,
    input  wire logic [1:0]       i_range,
    // Levels in units of 25 mV / 255
    output logic      [LVL_W-1:0] o_fast_level,
    output logic      [LVL_W-1:0] o_slow_level
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] ratio_pct(input logic [1:0] code);
        case (cbt_pkg::cbt_ratio_t'(code))
            cbt_pkg::CBT_RT_125: ratio_pct = `CBT_PCT_125;
            cbt_pkg::CBT_RT_150: ratio_pct = `CBT_PCT_150;
            cbt_pkg::CBT_RT_175: ratio_pct = `CBT_PCT_175;
            default:             ratio_pct = `CBT_PCT_200;
        endcase
    endfunction

    function automatic logic [2:0] range_mult(input logic [1:0] code);
        case (cbt_pkg::cbt_range_t'(code))
            cbt_pkg::CBT_FS_25MV: range_mult = 3'h1;
            cbt_pkg::CBT_FS_50MV: range_mult = 3'h2;
            default:              range_mult = 3'h4;
        endcase
    endfunction

    logic [LVL_W+6:0] scaled;

    // Fast level is dac/255 of full scale; slow is fast over the ratio
    always_comb begin
        o_fast_level = LVL_W'(i_dac) * LVL_W'(range_mult(i_range));
        scaled       = (LVL_W+7)'(o_fast_level) * (LVL_W+7)'(`CBT_PCT_BASE);
        o_slow_level = LVL_W'(scaled / ratio_pct(i_ratio));
    end

endmodule

`default_nettype wire

// ===== core/cbt_trip_detect.sv
`include "cbt_defines.svh"
`default_nettype none

module cbt_trip_detect #(
    parameter int          LVL_W      = 10,
    parameter int          ACC_W      = 16,
    parameter logic [15:0] SLOW_LIMIT = `CBT_SLOW_LIMIT,
    parameter logic [15:0] SLOW_LEAK  = `CBT_SLOW_LEAK
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Channel
    input  wire logic             i_chan_on,
    input  wire logic [LVL_W-1:0] i_sense_level,
    input  wire logic [LVL_W-1:0] i_fast_level,
    input  wire logic [LVL_W-1:0] i_slow_level,
    // Result
    output logic                  o_fault
);

    cbt_pkg::cbt_trip_state_t state_r, state_nxt;
    logic [ACC_W-1:0]         acc_r, acc_nxt;
    logic [ACC_W-1:0]         over;

    // ************************************************************
    // Breaker state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        over      = '0;
        case (state_r)
            cbt_pkg::CBT_ST_ARMED: begin
                if (i_sense_level > i_slow_level) begin
                    over = ACC_W'(i_sense_level - i_slow_level);
                end
                // Overdrive integrates; larger overdrive trips sooner
                if (over != '0) begin
                    acc_nxt = acc_r + over;
                end else if (acc_r > ACC_W'(SLOW_LEAK)) begin
                    acc_nxt = acc_r - ACC_W'(SLOW_LEAK);
                end else begin
                    acc_nxt = '0;
                end
                if (i_chan_on && (i_sense_level > i_fast_level)) begin
                    state_nxt = cbt_pkg::CBT_ST_TRIPPED;
                end else if (i_chan_on && (acc_nxt >= ACC_W'(SLOW_LIMIT))) begin
                    state_nxt = cbt_pkg::CBT_ST_TRIPPED;
                end
                if (!i_chan_on) begin
                    acc_nxt = '0;
                end
            end
            cbt_pkg::CBT_ST_TRIPPED: begin
                acc_nxt = '0;
                if (!i_chan_on) begin
                    state_nxt = cbt_pkg::CBT_ST_ARMED;
                end
            end
            default: begin
                state_nxt = cbt_pkg::CBT_ST_ARMED;
                acc_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r <= cbt_pkg::CBT_ST_ARMED;
            acc_r   <= '0;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
        end
    end

    assign o_fault = (state_r == cbt_pkg::CBT_ST_TRIPPED);

endmodule

`default_nettype wire

// ===== core/cbt_breaker_cfg.sv
// Chosen here: the strobed register port.
`include "cbt_defines.svh"
`default_nettype none

module cbt_breaker_cfg #(
    parameter int          NCH        = 4,
    parameter int          LVL_W      = 10,
    parameter logic [15:0] SLOW_LIMIT = `CBT_SLOW_LIMIT
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    // Register port
    input  wire logic [7:0]           i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    // Range pins, per channel 10 low, 01 high, 00 open
    input  wire logic [2*NCH-1:0]     i_range_select_input,
    // Channel state and sensed current
    input  wire logic [NCH-1:0]       i_chan_on,
    input  wire logic [NCH*LVL_W-1:0] i_sense_level,
    // Thresholds
    output logic      [NCH*LVL_W-1:0] o_fast_threshold_level,
    output logic      [NCH*LVL_W-1:0] o_slow_threshold_level,
    // Fault pins and gate shutdown
    output logic      [NCH-1:0]       o_fault_out,
    output logic      [NCH-1:0]       o_fault_oe,
    output logic      [NCH-1:0]       o_gate_off
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]           ratio_r, ratio_nxt;
    logic [7:0]           range_r, range_nxt;
    logic [7:0]           dac_r   [NCH];
    logic [7:0]           dac_nxt [NCH];
    logic                 loaded_r, loaded_nxt;
    logic [7:0]           rdata_r, rdata_nxt;
    logic [NCH*LVL_W-1:0] fast_r, fast_nxt;
    logic [NCH*LVL_W-1:0] slow_r, slow_nxt;
    logic [LVL_W-1:0]     fast_lvl [NCH];
    logic [LVL_W-1:0]     slow_lvl [NCH];
    logic [NCH-1:0]       fault;
    logic [NCH-1:0]       low_dac;

    function automatic logic is_dac_addr(input logic [7:0] a, input int ch);
        is_dac_addr = (a == 8'(`CBT_ADDR_DAC_BASE + ch));
    endfunction

    function automatic logic [1:0] field(input logic [7:0] v, input int ch);
        field = v[`CBT_FIELD_W*ch +: `CBT_FIELD_W];
    endfunction

    // ************************************************************
    // Register writes and range capture
    // ************************************************************
    always_comb begin
        ratio_nxt  = ratio_r;
        range_nxt  = range_r;
        loaded_nxt = 1'b1;
        for (int ch = 0; ch < NCH; ch++) begin
            dac_nxt[ch] = dac_r[ch];
        end
        if (!loaded_r) begin
            // First cycle after reset: take the strapped range codes
            for (int ch = 0; ch < NCH; ch++) begin
                range_nxt[`CBT_FIELD_W*ch +: `CBT_FIELD_W] =
                    (field(i_range_select_input, ch) == `CBT_RANGE_RESERVED) ?
                    2'h0 : field(i_range_select_input, ch);
            end
        end
        if (i_wr) begin
            if (i_addr == `CBT_ADDR_RATIO) begin
                ratio_nxt = i_wdata;
            end
            if (i_addr == `CBT_ADDR_RANGE) begin
                for (int ch = 0; ch < NCH; ch++) begin
                    if (field(i_wdata, ch) != `CBT_RANGE_RESERVED) begin
                        range_nxt[`CBT_FIELD_W*ch +: `CBT_FIELD_W] =
                            field(i_wdata, ch);
                    end
                end
            end
            for (int ch = 0; ch < NCH; ch++) begin
                if (is_dac_addr(i_addr, ch)) begin
                    dac_nxt[ch] = i_wdata;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ratio_r  <= `CBT_RATIO_RST;
            range_r  <= `CBT_RANGE_RST;
            loaded_r <= 1'b0;
            for (int ch = 0; ch < NCH; ch++) begin
                dac_r[ch] <= `CBT_DAC_RST;
            end
        end else begin
            ratio_r  <= ratio_nxt;
            range_r  <= range_nxt;
            loaded_r <= loaded_nxt;
            for (int ch = 0; ch < NCH; ch++) begin
                dac_r[ch] <= dac_nxt[ch];
            end
        end
    end

    // ************************************************************
    // Thresholds and breakers per channel
    // ************************************************************
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        cbt_thresh_calc #(
            .LVL_W        (LVL_W)
        ) u_calc (
            .i_dac        (dac_r[g]),
            .i_ratio      (field(ratio_r, g)),
            .i_range      (field(range_r, g)),
            .o_fast_level (fast_lvl[g]),
            .o_slow_level (slow_lvl[g])
        );

        cbt_trip_detect #(
            .LVL_W         (LVL_W),
            .SLOW_LIMIT    (SLOW_LIMIT)
        ) u_trip (
            .i_clk         (i_clk),
            .i_rst_b       (i_rst_b),
            .i_chan_on     (i_chan_on[g]),
            .i_sense_level (i_sense_level[LVL_W*g +: LVL_W]),
            .i_fast_level  (fast_lvl[g]),
            .i_slow_level  (slow_lvl[g]),
            .o_fault       (fault[g])
        );

        assign low_dac[g] = (dac_r[g] < `CBT_DAC_ACCURATE_MIN);
    end

    // ************************************************************
    // Read port and registered outputs
    // ************************************************************
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            if (i_addr == `CBT_ADDR_RATIO) begin
                rdata_nxt = ratio_r;
            end else if (i_addr == `CBT_ADDR_RANGE) begin
                rdata_nxt = range_r;
            end else if (i_addr == `CBT_ADDR_STATUS) begin
                rdata_nxt[`CBT_STAT_FAULT_LSB  +: NCH] = fault;
                rdata_nxt[`CBT_STAT_LOWDAC_LSB +: NCH] = low_dac;
            end
            for (int ch = 0; ch < NCH; ch++) begin
                if (is_dac_addr(i_addr, ch)) begin
                    rdata_nxt = dac_r[ch];
                end
            end
        end
        for (int ch = 0; ch < NCH; ch++) begin
            fast_nxt[LVL_W*ch +: LVL_W] = fast_lvl[ch];
            slow_nxt[LVL_W*ch +: LVL_W] = slow_lvl[ch];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rdata_r <= 8'h00;
            fast_r  <= '0;
            slow_r  <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            fast_r  <= fast_nxt;
            slow_r  <= slow_nxt;
        end
    end

    assign o_rdata                = rdata_r;
    assign o_fast_threshold_level = fast_r;
    assign o_slow_threshold_level = slow_r;
    // Open drain: pull low only while the channel is tripped
    assign o_fault_out            = '0;
    assign o_fault_oe             = fault;
    assign o_gate_off             = fault;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_ratio_wr;
        i_wr && (i_addr == `CBT_ADDR_RATIO);
    endsequence

    sequence s_range_wr;
        i_wr && (i_addr == `CBT_ADDR_RANGE);
    endsequence

    ratio_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $past(!i_rst_b) |-> ratio_r == `CBT_RATIO_RST)
        else $error("ratio byte not all ones after reset");

    ratio_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_ratio_wr |=> ratio_r == $past(i_wdata))
        else $error("ratio write not stored");

    range_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!loaded_r && !i_wr && i_range_select_input[1:0] != `CBT_RANGE_RESERVED)
        |=> range_r[1:0] == $past(i_range_select_input[1:0]))
        else $error("range not loaded from pin");

    range_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (s_range_wr and (i_wdata[1:0] != `CBT_RANGE_RESERVED))
        |=> range_r[1:0] == $past(i_wdata[1:0]))
        else $error("range write not stored");

    range_reserved_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (s_range_wr and (i_wdata[1:0] == `CBT_RANGE_RESERVED) and loaded_r)
        |=> $stable(range_r[1:0]))
        else $error("reserved range code took effect");

    dac_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_wr && i_addr == `CBT_ADDR_DAC_BASE) |=> dac_r[0] == $past(i_wdata))
        else $error("fast setting write not stored");

    fast_above_slow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (fast_lvl[0] != '0) |-> fast_lvl[0] > slow_lvl[0])
        else $error("slow level not below fast level");

    fast_trip_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_chan_on[0] && i_sense_level[LVL_W-1:0] > fast_lvl[0]) |=> o_fault_oe[0])
        else $error("fast trip missed");

    fault_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_fault_oe[0] && i_chan_on[0]) |=> o_fault_oe[0] && o_gate_off[0])
        else $error("fault dropped while channel on");

    ratio_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rd && i_addr == `CBT_ADDR_RATIO && !i_wr) |=> o_rdata == $past(ratio_r))
        else $error("ratio read mismatch");

    range_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rd && i_addr == `CBT_ADDR_RANGE) |=> o_rdata == $past(range_r))
        else $error("range read mismatch");

    status_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_rd && i_addr == `CBT_ADDR_STATUS)
        |=> o_rdata[`CBT_STAT_LOWDAC_LSB +: NCH] == $past(low_dac))
        else $error("low setting flags misread");

    ratio_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(i_wr && i_addr == `CBT_ADDR_RATIO) |=> $stable(ratio_r))
        else $error("ratio byte changed without a write");

    range_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (loaded_r && !(i_wr && i_addr == `CBT_ADDR_RANGE)) |=> $stable(range_r))
        else $error("range byte changed without a write");

    range_pin_open_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!loaded_r && !i_wr && i_range_select_input[1:0] == `CBT_RANGE_RESERVED)
        |=> range_r[1:0] == 2'h0)
        else $error("undefined pin code not mapped to widest range");

    fast_narrow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (field(range_r, 0) == 2'h2) |-> fast_lvl[0] == LVL_W'(dac_r[0]))
        else $error("narrow range fast level wrong");

    fast_wide_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (field(range_r, 0) == 2'h0) |-> fast_lvl[0] == LVL_W'({dac_r[0], 2'h0}))
        else $error("wide range fast level wrong");

    fast_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        1'b1 |=> o_fast_threshold_level[LVL_W-1:0] == $past(fast_lvl[0]))
        else $error("fast level output lags");

    slow_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        1'b1 |=> o_slow_threshold_level[LVL_W-1:0] == $past(slow_lvl[0]))
        else $error("slow level output lags");

    fault_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!i_chan_on[0]) |=> !o_fault_oe[0] && !o_gate_off[0])
        else $error("fault held with channel off");

endmodule

`default_nettype wire

// ===== dv/cbt_host_model.sv
`default_nettype none

module cbt_host_model (
    // Clock
    input  wire logic       i_clk,
    // Register port
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd,
    input  wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule

`default_nettype wire

// ===== dv/circuit_breaker_threshold_config_tb_top.sv
`include "cbt_defines.svh"
`default_nettype none

module circuit_breaker_threshold_config_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rst_b;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [7:0]  pins;
    logic [3:0]  chan_on;
    logic [39:0] sense;
    logic [39:0] fast_lvl;
    logic [39:0] slow_lvl;
    logic [3:0]  flt_out;
    logic [3:0]  flt_oe;
    logic [3:0]  gate_off;
    logic [7:0]  dac_m [4];
    logic [7:0]  ratio_m;
    logic [7:0]  range_m;
    int          n_errors;
    int          checks;

    cbt_host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
                         .o_rd(rd), .i_rdata(rdata));

    cbt_breaker_cfg #(.NCH(4), .LVL_W(10), .SLOW_LIMIT(16'h0040)) DUT (
        .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_range_select_input(pins), .i_chan_on(chan_on),
        .i_sense_level(sense), .o_fast_threshold_level(fast_lvl),
        .o_slow_threshold_level(slow_lvl), .o_fault_out(flt_out), .o_fault_oe(flt_oe),
        .o_gate_off(gate_off));

    always #5 clk = ~clk;

    // ************************************************************
    // Expectations
    // ************************************************************
    function automatic logic [9:0] fast_exp(logic [7:0] dac, logic [1:0] rng);
        return (rng == 2'h2) ? {2'h0, dac} : (rng == 2'h1) ? {1'b0, dac, 1'b0} : {dac, 2'h0};
    endfunction

    function automatic logic [9:0] slow_exp(logic [9:0] f, logic [1:0] r);
        logic [17:0] pct;
        pct = 18'h7D + 18'h19 * {16'h0000, r};
        return 10'(({8'h00, f} * 18'h64) / pct);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic wr_range(input logic [7:0] v);
        host.wr(`CBT_ADDR_RANGE, v);
        for (int c = 0; c < 4; c++) begin
            if (v[2*c+:2] != 2'h3) range_m[2*c+:2] = v[2*c+:2];
        end
    endtask

    task automatic check_all();
        logic [7:0] d;
        logic [7:0] st;
        logic [9:0] f;
        st = 8'h00;
        for (int c = 0; c < 4; c++) begin
            host.rd(`CBT_ADDR_DAC_BASE + 8'(c), d);
            chk({8'h00, d}, {8'h00, dac_m[c]}, "fast setting");
            if (dac_m[c] < 8'h66) st[4+c] = 1'b1;
        end
        host.rd(`CBT_ADDR_RATIO, d);
        chk({8'h00, d}, {8'h00, ratio_m}, "ratio byte");
        host.rd(`CBT_ADDR_RANGE, d);
        chk({8'h00, d}, {8'h00, range_m}, "range byte");
        host.rd(`CBT_ADDR_STATUS, d);
        chk({8'h00, d}, {8'h00, st}, "status byte");
        for (int c = 0; c < 4; c++) begin
            f = fast_exp(dac_m[c], range_m[2*c+:2]);
            chk({6'h00, fast_lvl[10*c+:10]}, {6'h00, f}, "fast level");
            chk({6'h00, slow_lvl[10*c+:10]}, {6'h00, slow_exp(f, ratio_m[2*c+:2])},
                "slow level");
        end
    endtask

    task automatic edge_flt(input logic exp, input string what);
        @(posedge clk);
        #1;
        chk({12'h000, flt_oe}, {15'h0000, exp}, what);
        chk({12'h000, gate_off}, {15'h0000, exp}, "gate off");
        chk({12'h000, flt_out}, 16'h0000, "fault value");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0] d;
        logic [1:0] c;
        logic       hit;
        clk      = 1'b0;
        rst_b    = 1'b0;
        pins     = 8'hD2;
        chan_on  = 4'h0;
        sense    = 40'h00_0000_0000;
        n_errors = 0;
        checks   = 0;
        for (int i = 0; i < 4; i++) dac_m[i] = `CBT_DAC_RST;
        ratio_m = `CBT_RATIO_RST;
        range_m = 8'h12;
        void'($urandom(17));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        check_all();
        $display("test reset done");

        host.wr(`CBT_ADDR_RATIO, 8'h1B);
        ratio_m = 8'h1B;
        wr_range(8'hE4);
        check_all();
        host.rd(8'h00, d);
        chk({8'h00, d}, 16'h0000, "unmapped read");
        host.wr(`CBT_ADDR_STATUS, 8'h55);
        host.wr(8'h70, 8'hAA);
        check_all();
        $display("test directed done");

        for (int n = 0; n < 16; n++) begin
            c = 2'($urandom);
            d = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : (n == 2) ? 8'h65 : 8'($urandom);
            host.wr(`CBT_ADDR_DAC_BASE + {6'h00, c}, d);
            dac_m[c] = d;
            ratio_m = 8'($urandom);
            host.wr(`CBT_ADDR_RATIO, ratio_m);
            wr_range(8'($urandom));
            check_all();
        end
        $display("test random done");

        @(posedge clk);
        rst_b <= 1'b0;
        pins  <= 8'h39;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) dac_m[i] = `CBT_DAC_RST;
        ratio_m = `CBT_RATIO_RST;
        range_m = 8'h09;
        check_all();
        $display("test second reset done");

        host.wr(`CBT_ADDR_DAC_BASE, 8'h80);
        host.wr(`CBT_ADDR_RATIO, 8'hFF);
        wr_range({range_m[7:2], 2'h2});
        @(posedge clk);
        sense[9:0] <= 10'h081;
        chan_on[0] <= 1'b1;
        edge_flt(1'b1, "fast trip");
        @(posedge clk);
        chan_on[0] <= 1'b0;
        sense[9:0] <= 10'h041;
        edge_flt(1'b0, "trip clear");
        @(posedge clk);
        chan_on[0] <= 1'b1;
        repeat (10) edge_flt(1'b0, "small overdrive");
        @(posedge clk);
        chan_on[0] <= 1'b0;
        sense[9:0] <= 10'h064;
        edge_flt(1'b0, "idle");
        @(posedge clk);
        chan_on[0] <= 1'b1;
        edge_flt(1'b0, "slow early");
        hit = 1'b0;
        for (int k = 0; k < 8 && !hit; k++) begin
            @(posedge clk);
            #1;
            hit = (flt_oe[0] === 1'b1);
        end
        chk({15'h0000, hit}, 16'h0001, "slow trip");
        $display("test breaker done");
        conclude();
    end
endmodule

`default_nettype wire
